//--- hdl/scpr_consts.vh
// constants for the serial configuration readout block
// Contract
// - While the output-enable/reset input is low the address counter clears and both outputs float.
// - While chip enable is high the address counter clears and both outputs float.
// - The controller supplies the clock and the block shifts the stored bitstream out on one data line.
// - The next bit is presented shortly after each rising configuration clock edge.
// - The default revision comes from the two select straps and the external select enable, all low meaning revision 0.
// - After power-on reset the output-enable/reset condition stays asserted between 0.5 ms and 30 ms before readout.
// - A core supply held below the power-down threshold for at least 10 ms forces a full internal reset; the core does not take the revision straps again.
`ifndef SCPR_CONSTS_VH
`define SCPR_CONSTS_VH
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define SCPR_CLK_HZ        25000000
`define SCPR_OER_MIN_US    500
`define SCPR_RST_MIN_US    10000
// ------------------------------------------------------------
// storage
// ------------------------------------------------------------
`define SCPR_ADDR_W        12
`define SCPR_REV_W         2
`define SCPR_REV_DEFAULT   2'h0
`define SCPR_STRAP_WAIT    2'h2
// ------------------------------------------------------------
// synchroniser bit positions
// ------------------------------------------------------------
`define SCPR_PIN_CLK       0
`define SCPR_PIN_OE        1
`define SCPR_PIN_CE_N      2
`define SCPR_PIN_CF        3
`define SCPR_PIN_LOW       4
`define SCPR_PIN_REV_LO    5
`define SCPR_PIN_REV_HI    6
`define SCPR_PIN_EXT_N     7
`endif

//--- hdl/scpr_readout.v
// serial configuration memory readout core
`include "scpr_consts.vh"
module scpr_readout #(
    parameter ADDR_W   = `SCPR_ADDR_W,                                   // bit address width
    parameter OER_CYC  = (`SCPR_OER_MIN_US * (`SCPR_CLK_HZ / 1000000)), // release delay cycles
    parameter RST_CYC  = (`SCPR_RST_MIN_US * (`SCPR_CLK_HZ / 1000000)), // brown-out trigger cycles
    parameter [4*(1<<`SCPR_ADDR_W)-1:0] IMAGE = {(1<<`SCPR_ADDR_W){4'hA}} // stored images
) (
    input  wire sys_clk_i,          // system clock
    input  wire rst_i,              // async reset, high
    input  wire ce_i,               // clock enable
    input  wire cfg_clk_i,          // configuration clock pin
    input  wire oe_reset_n_i,       // output enable / reset pin
    input  wire chip_enable_n_i,    // chip enable pin
    input  wire config_pulse_n_i,   // config pulse pin
    input  wire revision_select_lo_i, // revision strap 0
    input  wire revision_select_hi_i, // revision strap 1
    input  wire external_select_enable_n_i, // external select enable
    input  wire core_low_i,         // core supply below threshold
    output reg  serial_data_out_o,  // serial data
    output reg  serial_data_out_oe_o, // data drive enable
    output reg  cascade_clock_out_o,  // cascade clock
    output reg  cascade_clock_out_oe_o, // cascade drive enable
    output reg  ready_o             // release delay passed
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam SYNC_W = 8;                  // pins passing the synchroniser
    localparam CNT_W  = 32;                 // width of the delay counters

    reg  [SYNC_W-1:0] s1_q;                 // first stage, read by nothing else
    reg  [SYNC_W-1:0] s2_q;                 // second stage, read by the logic
    reg               clk_prev_q;           // last synchronised clock level
    wire [SYNC_W-1:0] pins_raw;             // pins gathered for sampling

    // pins gathered in one vector, all of them from outside this clock
    assign pins_raw = {external_select_enable_n_i,
                       revision_select_hi_i,
                       revision_select_lo_i,
                       core_low_i,
                       config_pulse_n_i,
                       chip_enable_n_i,
                       oe_reset_n_i,
                       cfg_clk_i};

    // two flops on every pin, only the second one is read
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_q <= {SYNC_W{1'b0}};
            s2_q <= {SYNC_W{1'b0}};
        end else if (ce_i) begin
            s1_q <= pins_raw;
            s2_q <= s1_q;
        end
    end

    // named views of the synchronised pins
    wire clk_s    = s2_q[`SCPR_PIN_CLK];
    wire oe_ok_s  = s2_q[`SCPR_PIN_OE];     // high lets the outputs drive
    wire ce_n_s   = s2_q[`SCPR_PIN_CE_N];
    wire cf_s     = s2_q[`SCPR_PIN_CF];
    wire low_s    = s2_q[`SCPR_PIN_LOW];
    wire rev_lo_s = s2_q[`SCPR_PIN_REV_LO];
    wire rev_hi_s = s2_q[`SCPR_PIN_REV_HI];
    wire ext_n_s  = s2_q[`SCPR_PIN_EXT_N];
    wire rise     = clk_s & ~clk_prev_q;    // rising config clock seen

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // one step of a counter that stops at its limit
    function [CNT_W-1:0] sat_inc;
        input [CNT_W-1:0] cnt;
        input [CNT_W-1:0] lim;
        begin
            if (cnt < lim)
                sat_inc = cnt + {{(CNT_W-1){1'b0}}, 1'b1};
            else
                sat_inc = cnt;
        end
    endfunction

    // counter stands in the last cycle of its delay
    function at_end;
        input [CNT_W-1:0] cnt;
        input [CNT_W-1:0] lim;
        begin
            at_end = (cnt >= lim - {{(CNT_W-1){1'b0}}, 1'b1});
        end
    endfunction

    // default revision from the straps, external select off means default
    function [`SCPR_REV_W-1:0] pick_rev;
        input ext_n;
        input hi;
        input lo;
        begin
            if (ext_n)
                pick_rev = `SCPR_REV_DEFAULT;
            else
                pick_rev = {hi, lo};
        end
    endfunction

    // ------------------------------------------------------------
    // brown-out detection
    // ------------------------------------------------------------
    reg [CNT_W-1:0] pd_cnt_q;               // cycles spent below threshold
    reg             pd_rst_q;               // reset request for sequencer, address counter and outputs

    // time below the power-down threshold, stops at the trigger count
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pd_cnt_q <= {CNT_W{1'b0}};
            pd_rst_q <= 1'b0;
        end else if (ce_i) begin
            if (low_s)
                pd_cnt_q <= sat_inc(pd_cnt_q, RST_CYC);
            else
                pd_cnt_q <= {CNT_W{1'b0}};
            pd_rst_q <= low_s && at_end(pd_cnt_q, RST_CYC);
        end
    end

    // ------------------------------------------------------------
    // release sequencer
    // ------------------------------------------------------------
    localparam [1:0] ST_HOLD  = 2'b00;      // release delay running
    localparam [1:0] ST_READY = 2'b01;      // readout allowed
    localparam [1:0] ST_DOWN  = 2'b10;      // supply dipped, reset held

    reg [1:0]       st_q;                   // sequencer state
    reg [1:0]       st_d;                   // next state
    reg [CNT_W-1:0] por_cnt_q;              // release delay count
    reg [CNT_W-1:0] por_cnt_d;              // next release delay count
    reg             rdy_q;                  // readout allowed

    // next state: count the release delay, restart it after a dip
    always @* begin
        st_d      = st_q;
        por_cnt_d = por_cnt_q;
        case (st_q)
            ST_HOLD: begin
                if (pd_rst_q) begin
                    st_d      = ST_DOWN;
                    por_cnt_d = {CNT_W{1'b0}};
                end else if (at_end(por_cnt_q, OER_CYC)) begin
                    st_d      = ST_READY;
                end else begin
                    por_cnt_d = sat_inc(por_cnt_q, OER_CYC);
                end
            end
            ST_READY: begin
                if (pd_rst_q) begin
                    st_d      = ST_DOWN;
                    por_cnt_d = {CNT_W{1'b0}};
                end
            end
            ST_DOWN: begin
                por_cnt_d = {CNT_W{1'b0}};
                if (!pd_rst_q)
                    st_d = ST_HOLD;
            end
            default: begin
                st_d      = ST_HOLD;
                por_cnt_d = {CNT_W{1'b0}};
            end
        endcase
    end

    // sequencer registers, ready flag taken from the next state
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q      <= ST_HOLD;
            por_cnt_q <= {CNT_W{1'b0}};
            rdy_q     <= 1'b0;
        end else if (ce_i) begin
            st_q      <= st_d;
            por_cnt_q <= por_cnt_d;
            rdy_q     <= (st_d == ST_READY);
        end
    end

    // ------------------------------------------------------------
    // revision strap capture
    // ------------------------------------------------------------
    reg [`SCPR_REV_W-1:0] rev_q;            // selected revision
    reg [1:0]             strap_wait_q;     // settle count for the straps
    reg                   strap_done_q;     // straps taken

    // straps taken once, after they have crossed the synchroniser
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rev_q        <= `SCPR_REV_DEFAULT;
            strap_wait_q <= 2'h0;
            strap_done_q <= 1'b0;
        end else if (ce_i && !strap_done_q) begin
            if (strap_wait_q == `SCPR_STRAP_WAIT) begin
                strap_done_q <= 1'b1;
                rev_q        <= pick_rev(ext_n_s, rev_hi_s, rev_lo_s);
            end else begin
                strap_wait_q <= strap_wait_q + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // address counter and shift out
    // ------------------------------------------------------------
    reg [ADDR_W-1:0] addr_q;                // bit address in the image
    wire enabled = rdy_q & ~pd_rst_q & oe_ok_s & ~ce_n_s & cf_s;
    // data index into the chosen image
    wire [ADDR_W+`SCPR_REV_W-1:0] bit_idx = {rev_q, addr_q};

    // counter clears when disabled, steps per rising clock
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_q     <= {ADDR_W{1'b0}};
            clk_prev_q <= 1'b0;
        end else if (ce_i) begin
            clk_prev_q <= clk_s;
            if (!enabled)
                addr_q <= {ADDR_W{1'b0}};
            else if (rise)
                addr_q <= addr_q + {{(ADDR_W-1){1'b0}}, 1'b1};
        end
    end

    // outputs registered, floated when disabled
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            serial_data_out_o      <= 1'b0;
            serial_data_out_oe_o   <= 1'b0;
            cascade_clock_out_o    <= 1'b0;
            cascade_clock_out_oe_o <= 1'b0;
            ready_o                <= 1'b0;
        end else if (ce_i) begin
            ready_o                <= rdy_q;
            serial_data_out_oe_o   <= enabled;
            cascade_clock_out_oe_o <= enabled;
            cascade_clock_out_o    <= enabled & clk_s;
            serial_data_out_o      <= enabled & IMAGE[bit_idx];
        end
    end
endmodule

//--- test/scpr_ctl_model.sv
// controller model: 320 ns clock master shifting in the data line
module scpr_ctl_model (input wire run_i, d_i, oe_i, output reg clk_o = 0,
    output reg [15:0] rx_o = 0, output int n_o = 0);
    timeunit 1ns; timeprecision 1ns;
    reg last_q = 0;
    always @* if (oe_i) last_q = d_i; // floating line shows the inverse
    initial forever begin // clock only while asked, bit taken before each rise
        wait (run_i);
        #160 rx_o = {rx_o[14:0], oe_i ? d_i : ~last_q};
        n_o++; clk_o = 1;
        #160 clk_o = 0;
    end
endmodule

//--- test/scpr_readout_bench.sv
// self-checking bench for the readout core
module scpr_readout_bench;
    timeunit 1ns; timeprecision 1ns;
    reg sys_clk_i = 0, rst_i = 1, ce_i = 1, oe_reset_n_i = 1, chip_enable_n_i = 1, run = 0;
    reg config_pulse_n_i = 1, revision_select_lo_i = 0, revision_select_hi_i = 0, core_low_i = 0;
    reg external_select_enable_n_i = 0;
    wire cfg_clk_i, serial_data_out_o, serial_data_out_oe_o, cascade_clock_out_o;
    wire cascade_clock_out_oe_o, ready_o; wire [15:0] rx;
    int n, mismatches = 0, check_count = 0;
    scpr_readout #(.OER_CYC(20), .RST_CYC(40),
        .IMAGE({{1024{4'h5}}, {1024{4'h6}}, {1024{4'h3}}, {1024{4'h3}}})) u_scpr_readout (.*);
    scpr_ctl_model u_scpr_ctl_model (.run_i(run), .d_i(serial_data_out_o),
        .oe_i(serial_data_out_oe_o), .clk_o(cfg_clk_i), .rx_o(rx), .n_o(n));
    initial forever #20 sys_clk_i = ~sys_clk_i;
    task check(string s, logic [7:0] e, logic [7:0] g); check_count++; mismatches += (g !== e);
        if (g !== e) $display("wrong value %s expected %h seen %h", s, e, g);
    endtask
    task results; $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed"); $finish; endtask
    task cyc(int k); repeat (k) @(posedge sys_clk_i); #1; endtask
    task hold(logic v); for (int i = 0; i < 200 && ready_o !== v; i++) cyc(1);
        if (ready_o !== v) begin mismatches++; results; end endtask
    task stream(int k); int s; bit seen; // enable the pins, clock k bits out
        seen = 0;
        {oe_reset_n_i, chip_enable_n_i, config_pulse_n_i} = 3'h5; cyc(6); s = n; run = 1;
        for (int i = 0; i < 200 && n - s < k; i++) begin
            cyc(1);
            seen |= (cascade_clock_out_o === 1'b1);
        end
        run = 0; cyc(8);
        check("bit count", k, n - s);
        check("clock echo", 8'h01, {7'h00, seen});
        if (n - s < k) begin mismatches++; results; end endtask
    task restrap; // second reset, straps now pick revision 2
        {revision_select_hi_i, revision_select_lo_i} = 2'h2;
        rst_i = 1; cyc(3); rst_i = 0; cyc(2);
        check("reset drive", 8'h00, {7'h00, serial_data_out_oe_o});
        hold(1); stream(8);
        check("rev bits", 8'h66, rx[7:0]); endtask
    task abort(int w); // refusal mid-stream, then restart from address zero
        stream(6);
        {oe_reset_n_i, chip_enable_n_i, config_pulse_n_i} = w == 0 ? 3'h1 : w == 1 ? 3'h7 : 3'h4;
        cyc(6);
        check("drive", 8'h00, {7'h00, serial_data_out_oe_o});
        stream(8);
        check("restart", 8'hCC, rx[7:0]); endtask
    initial begin
        cyc(3); rst_i = 0; cyc(10);
        check("ready", 8'h00, {7'h00, ready_o});
        hold(1); stream(8);
        check("bits", 8'hCC, rx[7:0]);
        for (int w = 0; w < 3; w++) abort(w);
        stream(6); core_low_i = 1; hold(0);
        core_low_i = 0; hold(1); stream(8);
        check("dip bits", 8'hCC, rx[7:0]);
        restrap;
        results;
    end
endmodule

//--- test/scpr_readout_properties.sv
// pin assertions for the readout core
module scpr_readout_properties (input wire sys_clk_i, rst_i, cfg_clk_i, oe_reset_n_i,
    chip_enable_n_i, config_pulse_n_i, core_low_i, serial_data_out_o, serial_data_out_oe_o,
    cascade_clock_out_oe_o, ready_o);
    wire oe = serial_data_out_oe_o;
    default clocking cb @(posedge sys_clk_i); endclocking default disable iff (rst_i);
    oe_float_a: assert property (!oe_reset_n_i [*5] |-> !oe) else $error("oe pin");
    ce_float_a: assert property (chip_enable_n_i [*5] |-> !oe) else $error("ce pin");
    pulse_float_a: assert property (!config_pulse_n_i [*5] |-> !oe) else $error("pulse");
    oe_pair_a: assert property (oe == cascade_clock_out_oe_o) else $error("pair");
    idle_zero_a: assert property (!oe |-> !serial_data_out_o) else $error("idle");
    ready_gate_a: assert property (!ready_o [*2] |-> !oe) else $error("drive");
    ready_hold_a: assert property ($fell(rst_i) |-> !ready_o [*8]) else $error("ready");
    data_hold_a: assert property ((!cfg_clk_i && oe) [*3] |-> $stable(serial_data_out_o))
        else $error("data moved");
    cover property ($rose(ready_o)); cover property ($rose(oe)); cover property (core_low_i [*8]);
endmodule
bind scpr_readout scpr_readout_properties u_scpr_readout_properties (.*);
